// ===== core/mdr_pkg.sv
// constants, codes and state type for the rounding/overflow sequencer
// assumes one 200 MHz clock and a host that decodes the request line
// Overview of operation
// - code 5 at a result state rounds and returns to idle
// - product rounding adds the bottom-half top bit into the top half
// - after product rounding: idle, bottom half cleared
// - quotient rounding sets quotient lsb unless the remainder is zero
// - after quotient rounding: idle, bottom half cleared
// - rounding works the same in integer and fractional mode
// - overflow cleared at each operation start, set on range violation
// - single fractional product overflows only for most negative times most negative; a single integer product never overflows
// - fractional product or accumulation outside 16-bit range overflows
// - fractional quotient outside 8-bit signed range overflows
// - integer division uses the same 8-bit signed quotient limits, unscaled
// - waiting states hold while the request line is high
// - code 7 reads top half, next clock with code 7 the bottom half
// - continual code 7 returns to idle within thirteen clocks
// - active-low master reset returns directly to idle
package mdr_pkg;
  localparam int DATA_W = 8;
  localparam logic [2:0] CODE_MAC = 3'h3;
  localparam logic [2:0] CODE_DIV = 3'h4;
  localparam logic [2:0] CODE_FRAC = 3'h5;
  localparam logic [2:0] CODE_INT = 3'h6;
  localparam logic [2:0] CODE_READ = 3'h7;
  localparam logic [2:0] CODE_ROUND = 3'h5;
  localparam int MUL_CYCLES = 8;
  localparam int DIV_CYCLES_INT = 10;
  localparam int DIV_CYCLES_FRAC = 9;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  typedef enum logic [2:0] {
    st_idle, st_x, st_z, st_mul, st_div, st_mend, st_dend
  } state_type;
endpackage

// ===== core/acc_if.sv
// carrier between the sequencer and the accumulator store
// assumes both ends share the system clock
`timescale 1ns/1ps
interface acc_if;
  logic we;
  logic [7:0] next_z;
  logic [7:0] next_w;
  logic [7:0] z;
  logic [7:0] w;
  logic [7:0] bus_q;
  modport ctrl (output we, output next_z, output next_w,
                input z, input w, input bus_q);
  modport store (input we, input next_z, input next_w,
                 output z, output w, output bus_q);
endinterface

// ===== core/acc_regs.sv
// double-length accumulator store, top and bottom halves
// assumes the controller presents both next halves with one write strobe
`timescale 1ns/1ps
module acc_regs (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_master_reset_n,
  acc_if.store acc
);
  // halves and a registered bus copy of the top half
  always_ff @(posedge i_clk_sys or negedge i_master_reset_n) begin
    if (!i_master_reset_n) begin
      acc.z <= mdr_pkg::ACC_RESET[15:8];
      acc.w <= mdr_pkg::ACC_RESET[7:0];
      acc.bus_q <= mdr_pkg::ACC_RESET[15:8];
    end else if (i_sys_rst) begin
      acc.z <= mdr_pkg::ACC_RESET[15:8];
      acc.w <= mdr_pkg::ACC_RESET[7:0];
      acc.bus_q <= mdr_pkg::ACC_RESET[15:8];
    end else if (acc.we) begin
      acc.z <= acc.next_z;
      acc.w <= acc.next_w;
      acc.bus_q <= acc.next_z; // bus always mirrors the top half
    end
  end
endmodule

// ===== core/mul_div_round_overflow.sv
// sequencer for multiply, divide, rounding, overflow and wait states
// assumes the host holds code and request steady around each clock edge
`timescale 1ns/1ps
module mul_div_round_overflow (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_master_reset_n,
  input wire logic [2:0] i_ins_code,
  input wire logic i_go_n,
  input wire logic [7:0] i_bus,
  output logic [7:0] o_bus,
  output logic o_bus_oe,
  output logic o_overflow_flag
);
  mdr_pkg::state_type state;
  mdr_pkg::state_type next_state;
  logic [7:0] x_op;
  logic [7:0] y_op;
  logic frac_mode;
  logic acc_mode;
  logic [3:0] busy_cnt;
  logic ovf_set;
  logic ovf_clr;
  logic [7:0] next_z;
  logic [7:0] next_w;
  logic acc_we;
  logic go;
  logic signed [17:0] prod;
  logic signed [17:0] mul_res;
  logic signed [16:0] dividend;
  logic signed [9:0] divisor;
  logic signed [16:0] quot;
  logic signed [16:0] rem;
  logic [8:0] round_sum;
  acc_if acc ();

  // 16-bit signed range check on a wider sum
  function automatic logic out16(input logic signed [17:0] v);
    out16 = (v > 18'sh07FFF) || (v < -18'sh08000);
  endfunction

  acc_regs u_acc (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_master_reset_n(i_master_reset_n),
    .acc(acc.store)
  );

  assign go = !i_go_n;
  assign acc.we = acc_we;
  assign acc.next_z = next_z;
  assign acc.next_w = next_w;
  assign o_bus = acc.bus_q;

  // bus drive while reading at a result or idle state
  // read enable
  assign o_bus_oe = go && (i_ins_code == mdr_pkg::CODE_READ) &&
    (state == mdr_pkg::st_idle || state == mdr_pkg::st_mend ||
     state == mdr_pkg::st_dend);

  // product with fractional scaling and optional accumulation
  always_comb begin
    prod = 18'(signed'(x_op)) * 18'(signed'(y_op));
    if (frac_mode) begin
      prod = prod <<< 1;
    end
    mul_res = acc_mode ? prod + 18'(signed'({acc.z, acc.w})) : prod;
  end

  // quotient and remainder; remainder keeps the dividend sign
  always_comb begin
    dividend = 17'(signed'({acc.z, acc.w}));
    divisor = frac_mode ? 10'(signed'(x_op)) <<< 1 : 10'(signed'(x_op));
    if (x_op == 8'h00) begin
      quot = 17'sh00000;
      rem = 17'sh00000;
    end else begin
      quot = dividend / 17'(divisor);
      rem = dividend - 17'(quot * 17'(divisor));
    end
    round_sum = {1'b0, acc.z} + {8'h00, acc.w[7]};
  end

  // state and accumulator next values
  always_comb begin
    next_state = state;
    next_z = acc.z;
    next_w = acc.w;
    acc_we = 1'b0;
    ovf_set = 1'b0;
    ovf_clr = 1'b0;
    case (state)
      mdr_pkg::st_idle: begin
        if (go && i_ins_code == mdr_pkg::CODE_READ) begin
          next_z = acc.w; // continual reads swap halves
          next_w = acc.z;
          acc_we = 1'b1;
        end else if (go && (i_ins_code == mdr_pkg::CODE_FRAC ||
                   i_ins_code == mdr_pkg::CODE_INT)) begin
          next_state = mdr_pkg::st_x;
        end
      end
      mdr_pkg::st_x: begin
        if (go) begin
          if (i_ins_code == mdr_pkg::CODE_READ) begin
            next_state = mdr_pkg::st_idle;
          end else if (i_ins_code == mdr_pkg::CODE_DIV) begin
            next_z = i_bus;
            acc_we = 1'b1;
            next_state = mdr_pkg::st_z;
          end else begin
            ovf_clr = 1'b1;
            next_state = mdr_pkg::st_mul;
          end
        end
      end
      mdr_pkg::st_z: begin
        if (go) begin
          if (i_ins_code == mdr_pkg::CODE_READ) begin
            next_state = mdr_pkg::st_idle;
          end else begin
            next_w = i_bus;
            acc_we = 1'b1;
            ovf_clr = 1'b1;
            next_state = mdr_pkg::st_div;
          end
        end
      end
      mdr_pkg::st_mul: begin
        if (busy_cnt == 4'(mdr_pkg::MUL_CYCLES - 1)) begin
          next_z = mul_res[15:8];
          next_w = mul_res[7:0];
          acc_we = 1'b1;
          ovf_set = out16(mul_res);
          next_state = mdr_pkg::st_mend;
        end
      end
      mdr_pkg::st_div: begin
        if (busy_cnt == (frac_mode ? 4'(mdr_pkg::DIV_CYCLES_FRAC - 1) :
                         4'(mdr_pkg::DIV_CYCLES_INT - 1))) begin
          next_z = quot[7:0];
          next_w = rem[7:0];
          acc_we = 1'b1;
          ovf_set = (x_op == 8'h00) || (quot > 17'sh0007F) ||
                    (quot < -17'sh00080);
          next_state = mdr_pkg::st_dend;
        end
      end
      mdr_pkg::st_mend, mdr_pkg::st_dend: begin
        if (go) begin
          if (i_ins_code == mdr_pkg::CODE_READ) begin
            next_z = acc.w;
            next_w = acc.z;
            acc_we = 1'b1;
            next_state = mdr_pkg::st_idle;
          end else if (i_ins_code == mdr_pkg::CODE_ROUND) begin
            acc_we = 1'b1;
            next_w = 8'h00; // bottom cleared
            next_state = mdr_pkg::st_idle;
            if (state == mdr_pkg::st_mend) begin
              next_z = round_sum[7:0];
              ovf_set = !acc.z[7] && round_sum[7];
            end else begin
              next_z = {acc.z[7:1], acc.z[0] | (acc.w != 8'h00)};
            end
          end else if (i_ins_code == mdr_pkg::CODE_INT) begin
            next_state = mdr_pkg::st_x; // chain with a new operand
          end else begin
            next_state = mdr_pkg::st_idle;
          end
        end
      end
      default: begin
        next_state = mdr_pkg::st_idle;
      end
    endcase
  end

  // state register
  // master reset to idle
  always_ff @(posedge i_clk_sys or negedge i_master_reset_n) begin
    if (!i_master_reset_n) begin
      state <= mdr_pkg::st_idle;
    end else if (i_sys_rst) begin
      state <= mdr_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // operand and mode capture
  always_ff @(posedge i_clk_sys or negedge i_master_reset_n) begin
    if (!i_master_reset_n) begin
      x_op <= 8'h00;
      y_op <= 8'h00;
      frac_mode <= 1'b1;
      acc_mode <= 1'b0;
    end else if (i_sys_rst) begin
      x_op <= 8'h00;
      y_op <= 8'h00;
      frac_mode <= 1'b1;
      acc_mode <= 1'b0;
    end else if (go && (state == mdr_pkg::st_idle ||
                 state == mdr_pkg::st_mend || state == mdr_pkg::st_dend) &&
                 next_state == mdr_pkg::st_x) begin
      x_op <= i_bus;
      frac_mode <= (i_ins_code == mdr_pkg::CODE_FRAC);
    end else if (state == mdr_pkg::st_x && next_state == mdr_pkg::st_mul) begin
      y_op <= i_bus;
      acc_mode <= (i_ins_code == mdr_pkg::CODE_MAC);
    end
  end

  // busy cycle counter
  always_ff @(posedge i_clk_sys or negedge i_master_reset_n) begin
    if (!i_master_reset_n) begin
      busy_cnt <= 4'h0;
    end else if (i_sys_rst || next_state != state) begin
      busy_cnt <= 4'h0;
    end else begin
      busy_cnt <= busy_cnt + 4'h1;
    end
  end

  // overflow flag, set wins over clear
  // sticky overflow
  always_ff @(posedge i_clk_sys or negedge i_master_reset_n) begin
    if (!i_master_reset_n) begin
      o_overflow_flag <= 1'b0;
    end else if (i_sys_rst) begin
      o_overflow_flag <= 1'b0;
    end else if (ovf_set) begin
      o_overflow_flag <= 1'b1;
    end else if (ovf_clr) begin
      o_overflow_flag <= 1'b0;
    end
  end
endmodule

// ===== verification/mdr_properties.sv
// checker for bus enable, read pairing, wait states, overflow and reset
// assumes it is bound to the sequencer top module
`timescale 1ns/1ps
module mdr_properties (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_master_reset_n,
  input wire logic [2:0] i_ins_code,
  input wire logic i_go_n,
  input wire logic [7:0] i_bus,
  input wire logic [7:0] o_bus,
  input wire logic o_bus_oe,
  input wire logic o_overflow_flag
);
  logic [3:0] rd_cnt;
  logic [3:0] hi_cnt;
  wire rd_req = !i_go_n && i_ins_code == 3'h7;
  // run length of read requests
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !rd_req) rd_cnt <= 4'h0;
    else if (rd_cnt != 4'hF) rd_cnt <= rd_cnt + 4'h1;
  end
  // run length of an idle request line
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_master_reset_n || !i_go_n) hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst || !i_master_reset_n);
  a_oe_needs_read: assert property (o_bus_oe |-> rd_req)
    else $error("bus enable without read request");
  a_read_swap: assert property (
    o_bus_oe [*3] |-> o_bus == $past(o_bus, 2))
    else $error("read did not alternate halves");
  a_read_again: assert property (o_bus_oe ##1 rd_req |-> o_bus_oe)
    else $error("second read cycle not driven");
  a_code7_idle: assert property (
    rd_req && rd_cnt >= 4'hD |-> o_bus_oe)
    else $error("continual reads did not reach idle");
  a_wait_hold: assert property (
    hi_cnt >= 4'hC |-> $stable(o_bus) && $stable(o_overflow_flag))
    else $error("outputs moved during wait");
  a_ovf_hold: assert property (
    o_overflow_flag && i_go_n |=> o_overflow_flag)
    else $error("overflow dropped without operation");
  a_ovf_clear_start: assert property (
    $fell(o_overflow_flag) |-> !$past(i_go_n))
    else $error("overflow cleared without request");
  a_mreset_clear: assert property (disable iff (i_sys_rst)
    !i_master_reset_n |-> o_bus == 8'h00 && !o_overflow_flag)
    else $error("master reset did not clear outputs");
  a_sreset_clear: assert property (disable iff (!i_master_reset_n)
    i_sys_rst |=> o_bus == 8'h00 && !o_overflow_flag)
    else $error("reset did not clear outputs");
  // main scenarios reached
  cover property (o_bus_oe [*2]);
  cover property ($rose(o_overflow_flag));
  cover property (rd_cnt == 4'hD);
endmodule

bind mul_div_round_overflow mdr_properties i_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_master_reset_n(i_master_reset_n), .i_ins_code(i_ins_code),
  .i_go_n(i_go_n), .i_bus(i_bus), .o_bus(o_bus), .o_bus_oe(o_bus_oe),
  .o_overflow_flag(o_overflow_flag)
);

// ===== verification/host_model.sv
// host processor: code from low address bits, request from decoder
// assumes the bench calls put once for each cycle it wants to drive
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk_sys,
  output logic [2:0] o_ins_code,
  output logic o_go_n,
  output logic [7:0] o_bus
);
  logic [7:0] last = 8'h00;
  initial begin
    o_ins_code = 3'h0;
    o_go_n = 1'b1;
    o_bus = 8'hFF;
  end
  // mode and round codes come from the caller
  task automatic put(input logic [2:0] c, input logic s, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_ins_code = c;
    o_go_n = !s;
    if (s) last = d;
    o_bus = s ? d : ~last; // released bus shows no stale value
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the rounding and overflow sequencer
// assumes the host model drives code, request and bus on falling edges
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mrst_n = 1'b1;
  logic [2:0] code;
  logic go_n, oe, ovf;
  logic [7:0] hbus, dbus, bus_w;
  int bad_count = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  // wire level of the shared bus
  assign bus_w = oe ? dbus : hbus;
  host_model i_host (.i_clk_sys(clk), .o_ins_code(code), .o_go_n(go_n),
    .o_bus(hbus));
  mul_div_round_overflow i_dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_master_reset_n(mrst_n), .i_ins_code(code), .i_go_n(go_n),
    .i_bus(bus_w), .o_bus(dbus), .o_bus_oe(oe), .o_overflow_flag(ovf));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic ld(input logic [2:0] c, input logic [7:0] d);
    i_host.put(c, 1'b1, d);
  endtask
  task automatic hold(input int n);
    repeat (n) i_host.put(3'h0, 1'b0, 8'h00);
  endtask
  task automatic rd(input logic [7:0] z, input logic [7:0] w, input logic f);
    ld(3'h7, 8'h00);
    #1;
    chk({7'h00, oe}, 8'h01);
    chk(dbus, z);
    chk({7'h00, ovf}, {7'h00, f});
    ld(3'h7, 8'h00);
    #1;
    chk(dbus, w);
    hold(1);
  endtask
  task automatic t_idle;
    hold(5);
    #1;
    chk({7'h00, oe}, 8'h00);
    rd(8'h00, 8'h00, 1'b0);
    $display("test idle done");
  endtask
  task automatic t_mul_round(input logic [2:0] m, input logic [7:0] x,
                             input logic [7:0] y, input logic [7:0] z);
    ld(m, x);
    ld(m, y);
    hold(12);
    ld(3'h5, 8'h00);
    rd(z, 8'h00, 1'b0);
    $display("test multiply round done");
  endtask
  task automatic t_mul_ovf;
    ld(3'h5, 8'h80);
    ld(3'h5, 8'h80);
    hold(12);
    chk({7'h00, ovf}, 8'h01);
    hold(3);
    chk({7'h00, ovf}, 8'h01);
    ld(3'h0, 8'h00);
    ld(3'h5, 8'h40);
    ld(3'h5, 8'h40);
    hold(1);
    #1;
    chk({7'h00, ovf}, 8'h00);
    hold(11);
    rd(8'h20, 8'h00, 1'b0);
    // accumulate 0x7E02 onto 0x2000: leaves the 16-bit range
    ld(3'h5, 8'h7F);
    ld(3'h3, 8'h7F);
    hold(12);
    rd(8'h9E, 8'h02, 1'b1);
    $display("test multiply overflow done");
  endtask
  task automatic t_div_round(input logic [7:0] lo, input logic [7:0] q);
    ld(3'h6, 8'h07);
    ld(3'h4, 8'h00);
    ld(3'h0, lo);
    hold(14);
    ld(3'h5, 8'h00);
    rd(q, 8'h00, 1'b0);
    $display("test divide round done");
  endtask
  task automatic t_div_ovf(input logic [2:0] m, input logic [7:0] x,
                           input logic [7:0] z);
    ld(m, x);
    ld(3'h4, z);
    ld(3'h0, 8'h00);
    hold(14);
    chk({7'h00, ovf}, 8'h01);
    mrst_n = 1'b0;
    #1;
    chk({7'h00, ovf}, 8'h00);
    chk(dbus, 8'h00);
    @(negedge clk);
    mrst_n = 1'b1;
    $display("test divide overflow done");
  endtask
  task automatic t_abort;
    // read breaks a half-loaded sequence
    ld(3'h6, 8'h05);
    ld(3'h7, 8'h00);
    ld(3'h7, 8'h00);
    #1;
    chk({7'h00, oe}, 8'h01);
    hold(1);
    // reads presented from the start of an integer division 16/5
    ld(3'h6, 8'h05);
    ld(3'h4, 8'h00);
    ld(3'h0, 8'h10);
    repeat (13) ld(3'h7, 8'h00);
    #1;
    chk({7'h00, oe}, 8'h01);
    repeat (2) ld(3'h7, 8'h00);
    #1;
    chk(dbus, 8'h03);
    hold(1);
    $display("test abort done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #100000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_idle;
    t_mul_round(3'h6, 8'h0C, 8'h10, 8'h01);
    t_mul_round(3'h5, 8'h48, 8'h48, 8'h29);
    t_mul_ovf;
    t_div_round(8'h64, 8'h0F);
    t_div_round(8'h62, 8'h0E);
    t_div_ovf(3'h6, 8'h01, 8'h10);
    t_div_ovf(3'h5, 8'h20, 8'h40);
    t_abort;
    test_done;
  end
endmodule
